//--- design/dca_cmd_front.sv
// command decoder, bank tracker and clock-enable power state of the sdram
`timescale 1ns/1ps
// Functional notes
// - activate takes the row address from the address inputs and opens it
// - read/write take column address; address bit 10 requests auto precharge
// - precharge: bit 10 low closes selected bank, high closes all banks
// - mode-register load takes its operation code from the address inputs
// - bank-select inputs pick the bank for activate, read, write, precharge
// - bank-select picks base or extended mode register on a mode load
// - inputs sampled on true clock rising, complement clock falling crossing
// - output data and strobe timing referenced to the clock crossings
// - clock-enable high runs internal clock, buffers, drivers; low stops them
// - clock-enable low: idle banks enter precharge power-down or self refresh, else active power-down
// - power-down entry/exit and self refresh entry use clocked clock-enable
// - self refresh exit and output disable follow clock-enable without clock edge
// - in power-down only clock pair and clock-enable buffers remain active
// - in self refresh only the clock-enable buffer remains active
// - clock-enable treated as low after power-up until first driven high
// - chip select high masks every command; decode only when it is low
// - row strobe, column strobe, write-enable and chip select form the command
module dca_cmd_front (
   input  wire logic                        clk,             // system clock, 125 MHz
   input  wire logic                        reset,           // synchronous, active high
   input  wire logic                        clk_true,        // link clock, true phase
   input  wire logic                        clk_complement,  // link clock, complement phase
   input  wire logic                        cke,             // clock enable pin
   input  wire logic                        cs_n,            // chip select, active low
   input  wire logic                        ras_n,           // row strobe, active low
   input  wire logic                        cas_n,           // column strobe, active low
   input  wire logic                        we_n,            // write enable, active low
   input  wire logic [dca_pkg::ADDR_W-1:0]  addr,            // address inputs
   input  wire logic                        bank_select_lsb, // bank select bit 0
   input  wire logic                        bank_select_msb, // bank select bit 1
   output logic                             act_strobe,      // activate decoded pulse
   output logic                             rd_strobe,       // read decoded pulse
   output logic                             wr_strobe,       // write decoded pulse
   output logic                             pre_strobe,      // precharge decoded pulse
   output logic                             ref_strobe,      // auto refresh decoded pulse
   output logic                             mode_strobe,     // base mode load pulse
   output logic                             ext_mode_strobe, // extended mode load pulse
   output logic [dca_pkg::BANK_W-1:0]       cmd_bank,        // bank of decoded command
   output logic [dca_pkg::ROW_W-1:0]        row_addr,        // row for activate
   output logic [dca_pkg::COL_W-1:0]        col_addr,        // column for read/write
   output logic                             auto_pre,        // auto precharge with access
   output logic                             pre_all,         // precharge applies to all banks
   output logic [dca_pkg::ADDR_W-1:0]       mode_opcode,     // operation code of mode load
   output logic [dca_pkg::NUM_BANKS-1:0]    bank_open,       // per-bank row open flags
   output logic [1:0]                       pwr_state,       // dca_pwr_t encoding
   output logic                             int_clk_en,      // internal clock running
   output logic                             out_drv_en,      // output drivers enabled
   output logic                             cmd_buf_en,      // command/address buffers on
   output logic                             ck_buf_en,       // clock pair buffers on
   output logic                             io_edge          // crossing pulse for output timing
);

   // ==========================================================
   // input synchronisers
   // ==========================================================
   logic [1:0] ckt_s_r, ckc_s_r, cke_s_r;
   logic       ckt_d_r, ckc_d_r;
   logic [3:0] ctl_s1_r, ctl_s2_r;
   logic [dca_pkg::ADDR_W-1:0] addr_s1_r, addr_s2_r;
   logic [1:0] ba_s1_r, ba_s2_r;

   // two flops on every pin before use
   always_ff @(posedge clk) begin
      ckt_s_r   <= {ckt_s_r[0], clk_true};
      ckc_s_r   <= {ckc_s_r[0], clk_complement};
      cke_s_r   <= {cke_s_r[0], cke};
      ctl_s1_r  <= {cs_n, ras_n, cas_n, we_n};
      ctl_s2_r  <= ctl_s1_r;
      addr_s1_r <= addr;
      addr_s2_r <= addr_s1_r;
      ba_s1_r   <= {bank_select_msb, bank_select_lsb};
      ba_s2_r   <= ba_s1_r;
   end

   // previous synchronised clock phases for edge detection
   always_ff @(posedge clk) begin
      ckt_d_r <= ckt_s_r[1];
      ckc_d_r <= ckc_s_r[1];
   end

   logic crossing;
   logic cke_now;
   assign cke_now  = cke_s_r[1];
   // true rises while complement falls
   assign crossing = ckt_s_r[1] & ~ckt_d_r & ~ckc_s_r[1] & ckc_d_r;

   // ==========================================================
   // power state
   // ==========================================================
   dca_pkg::dca_pwr_t pwr_r;
   logic     cke_seen_r;   // clock enable driven high at least once
   logic     cke_q_r;      // clock enable registered at last crossing, set on self refresh exit
   logic     all_idle;
   logic     decode_ok;
   logic [2:0] cmd;

   assign all_idle = ~|bank_open;
   assign cmd      = ctl_s2_r[2:0];
   // commands only on a crossing while active, clock enable high and cs low
   assign decode_ok = crossing & cke_q_r & cke_now & ~ctl_s2_r[3]
                      & (pwr_r == dca_pkg::DCA_PWR_ACTIVE);

   // first high on clock enable arms it
   always_ff @(posedge clk) begin
      if (reset) begin
         cke_seen_r <= 1'b0;
      end else if (cke_now) begin
         cke_seen_r <= 1'b1;
      end
   end

   // clock enable registered on crossings, set at once when it rises in self refresh
   always_ff @(posedge clk) begin
      if (reset) begin
         cke_q_r <= 1'b0;
      end else if (pwr_r == dca_pkg::DCA_PWR_SELF_REF && cke_now) begin
         cke_q_r <= 1'b1;
      end else if (crossing) begin
         cke_q_r <= cke_now & cke_seen_r;
      end
   end

   // power-down and self refresh transitions
   always_ff @(posedge clk) begin
      if (reset) begin
         pwr_r <= dca_pkg::DCA_PWR_PRE_PD;
      end else begin
         case (pwr_r)
            dca_pkg::DCA_PWR_ACTIVE: begin
               if (crossing && !cke_now) begin
                  // refresh command with cke falling enters self refresh
                  if (all_idle && !ctl_s2_r[3] && cmd == dca_pkg::CMD_REF) begin
                     pwr_r <= dca_pkg::DCA_PWR_SELF_REF;
                  end else if (all_idle) begin
                     pwr_r <= dca_pkg::DCA_PWR_PRE_PD;
                  end else begin
                     pwr_r <= dca_pkg::DCA_PWR_ACT_PD;
                  end
               end
            end
            dca_pkg::DCA_PWR_PRE_PD,
            dca_pkg::DCA_PWR_ACT_PD: begin
               if (crossing && cke_now && cke_seen_r) begin
                  pwr_r <= dca_pkg::DCA_PWR_ACTIVE;
               end
            end
            dca_pkg::DCA_PWR_SELF_REF: begin
               if (cke_now) begin
                  pwr_r <= dca_pkg::DCA_PWR_ACTIVE;
               end
            end
            default: pwr_r <= dca_pkg::DCA_PWR_PRE_PD;
         endcase
      end
   end

   // buffer and driver enables follow the power state
   always_ff @(posedge clk) begin
      if (reset) begin
         int_clk_en <= 1'b0;
         out_drv_en <= 1'b0;
         cmd_buf_en <= 1'b0;
         ck_buf_en  <= 1'b1;
         pwr_state  <= 2'h1;
      end else begin
         int_clk_en <= (pwr_r == dca_pkg::DCA_PWR_ACTIVE);
         out_drv_en <= (pwr_r == dca_pkg::DCA_PWR_ACTIVE) & cke_now;
         cmd_buf_en <= (pwr_r == dca_pkg::DCA_PWR_ACTIVE);
         ck_buf_en  <= (pwr_r != dca_pkg::DCA_PWR_SELF_REF);
         pwr_state  <= pwr_r;
      end
   end

   // crossing marker for data and strobe launch timing
   always_ff @(posedge clk) begin
      if (reset) begin
         io_edge <= 1'b0;
      end else begin
         io_edge <= crossing & out_drv_en;
      end
   end

   // ==========================================================
   // command decode
   // ==========================================================
   logic [dca_pkg::BANK_W-1:0] ba;
   logic ap_bit;
   assign ba     = ba_s2_r;
   assign ap_bit = addr_s2_r[dca_pkg::AP_POS];

   // one-cycle strobes per decoded command
   always_ff @(posedge clk) begin
      if (reset) begin
         act_strobe      <= 1'b0;
         rd_strobe       <= 1'b0;
         wr_strobe       <= 1'b0;
         pre_strobe      <= 1'b0;
         ref_strobe      <= 1'b0;
         mode_strobe     <= 1'b0;
         ext_mode_strobe <= 1'b0;
      end else begin
         act_strobe      <= decode_ok & (cmd == dca_pkg::CMD_ACT);
         rd_strobe       <= decode_ok & (cmd == dca_pkg::CMD_RD);
         wr_strobe       <= decode_ok & (cmd == dca_pkg::CMD_WR);
         pre_strobe      <= decode_ok & (cmd == dca_pkg::CMD_PRE);
         ref_strobe      <= decode_ok & (cmd == dca_pkg::CMD_REF);
         mode_strobe     <= decode_ok & (cmd == dca_pkg::CMD_MRS)
                            & (ba == dca_pkg::MODE_SEL_BASE);
         ext_mode_strobe <= decode_ok & (cmd == dca_pkg::CMD_MRS)
                            & (ba == dca_pkg::MODE_SEL_EXT);
      end
   end

   // address fields captured with their command
   always_ff @(posedge clk) begin
      if (reset) begin
         cmd_bank    <= dca_pkg::BANK_RST;
         row_addr    <= dca_pkg::ADDR_RST;
         col_addr    <= dca_pkg::COL_W'(0);
         auto_pre    <= 1'b0;
         pre_all     <= 1'b0;
         mode_opcode <= dca_pkg::ADDR_RST;
      end else if (decode_ok) begin
         case (cmd)
            dca_pkg::CMD_ACT: begin
               cmd_bank <= ba;
               row_addr <= addr_s2_r;
            end
            dca_pkg::CMD_RD,
            dca_pkg::CMD_WR: begin
               cmd_bank <= ba;
               col_addr <= {addr_s2_r[dca_pkg::COL_W:dca_pkg::AP_POS+1],
                            addr_s2_r[dca_pkg::AP_POS-1:0]};
               auto_pre <= ap_bit;
            end
            dca_pkg::CMD_PRE: begin
               cmd_bank <= ba;
               pre_all  <= ap_bit;
            end
            dca_pkg::CMD_MRS: begin
               if (ba == dca_pkg::MODE_SEL_BASE || ba == dca_pkg::MODE_SEL_EXT) begin
                  mode_opcode <= addr_s2_r;
               end
            end
            default: begin
               cmd_bank <= cmd_bank;
            end
         endcase
      end
   end

   // ==========================================================
   // per-bank open row tracking
   // ==========================================================
   genvar gb;
   generate
      for (gb = 0; gb < dca_pkg::NUM_BANKS; gb++) begin : g_bank
         // open on activate, close on precharge or auto precharge
         always_ff @(posedge clk) begin
            if (reset) begin
               bank_open[gb] <= 1'b0;
            end else if (decode_ok) begin
               if (cmd == dca_pkg::CMD_ACT && ba == dca_pkg::BANK_W'(gb)) begin
                  bank_open[gb] <= 1'b1;
               end else if (cmd == dca_pkg::CMD_PRE && (ap_bit || ba == dca_pkg::BANK_W'(gb))) begin
                  bank_open[gb] <= 1'b0;
               end else if ((cmd == dca_pkg::CMD_RD || cmd == dca_pkg::CMD_WR)
                            && ba == dca_pkg::BANK_W'(gb) && ap_bit) begin
                  bank_open[gb] <= 1'b0;
               end
            end
         end
      end
   endgenerate

endmodule

//--- inc/dca_pkg.sv
// constants for the sdram command, address and clock-enable front end
package dca_pkg;
   localparam int ADDR_W       = 14;
   localparam int BANK_W       = 2;
   localparam int NUM_BANKS    = 4;
   localparam int ROW_W        = 14;
   localparam int COL_W        = 12;
   localparam int AP_POS       = 10;   // auto precharge / precharge scope bit position
   localparam logic [1:0] MODE_SEL_BASE = 2'h0;
   localparam logic [1:0] MODE_SEL_EXT  = 2'h1;
   localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
   localparam logic [1:0]  BANK_RST = 2'h0;
   // command codes {ras_n, cas_n, we_n}
   localparam logic [2:0] CMD_MRS  = 3'h0;
   localparam logic [2:0] CMD_REF  = 3'h1;
   localparam logic [2:0] CMD_PRE  = 3'h2;
   localparam logic [2:0] CMD_ACT  = 3'h3;
   localparam logic [2:0] CMD_WR   = 3'h4;
   localparam logic [2:0] CMD_RD   = 3'h5;
   localparam logic [2:0] CMD_BST  = 3'h6;
   localparam logic [2:0] CMD_NOP  = 3'h7;
   typedef enum logic [1:0] {
      DCA_PWR_ACTIVE,
      DCA_PWR_PRE_PD,
      DCA_PWR_ACT_PD,
      DCA_PWR_SELF_REF
   } dca_pwr_t;
endpackage

//--- verif/dca_cmd_front_props.sv
// port assertions for the command front end
`timescale 1ns/1ps
module dca_cmd_front_props (
   input wire logic       clk,             // system clock
   input wire logic       reset,           // sync reset
   input wire logic       cke,             // clock enable pin
   input wire logic       act_strobe,      // activate pulse
   input wire logic       rd_strobe,       // read pulse
   input wire logic       wr_strobe,       // write pulse
   input wire logic       pre_strobe,      // precharge pulse
   input wire logic       ref_strobe,      // refresh pulse
   input wire logic       mode_strobe,     // base mode pulse
   input wire logic       ext_mode_strobe, // extended mode pulse
   input wire logic [1:0] cmd_bank,        // bank of command
   input wire logic       pre_all,         // all-bank precharge
   input wire logic [3:0] bank_open,       // open rows
   input wire logic [1:0] pwr_state,       // power state
   input wire logic       int_clk_en,      // internal clock
   input wire logic       out_drv_en,      // drivers on
   input wire logic       cmd_buf_en,      // command buffers
   input wire logic       ck_buf_en,       // clock buffers
   input wire logic       io_edge          // output timing pulse
);
   wire logic [6:0] stb = {act_strobe, rd_strobe, wr_strobe, pre_strobe, ref_strobe, mode_strobe, ext_mode_strobe};
   // ==========================================
   // power state held for two cycles
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   sequence s_stay(logic [1:0] st);
      pwr_state == st && $past(pwr_state) == st;
   endsequence
   sequence s_quiet;
      stb == 7'h00;
   endsequence
   a_strobe_onehot: assert property ($onehot0(stb)) else $error("two strobes at once");
   a_strobe_pulse: assert property (stb != 7'h00 |=> s_quiet) else $error("strobe longer than one cycle");
   a_act_opens: assert property (act_strobe |-> ##[0:1] bank_open[cmd_bank]) else $error("row not opened");
   a_pre_one: assert property (pre_strobe && !pre_all |-> ##[0:1] !bank_open[cmd_bank]) else $error("bank left open");
   a_pre_every: assert property (pre_strobe && pre_all |-> ##[0:1] bank_open == 4'h0) else $error("banks left open");
   a_no_cmd_pd: assert property (pwr_state != 2'h0 && $past(pwr_state) != 2'h0 |-> s_quiet) else $error("decode asleep");
   a_bufs_pd: assert property ((s_stay(2'h1) or s_stay(2'h2)) |-> ck_buf_en && !cmd_buf_en) else $error("pd buffers");
   a_bufs_sr: assert property (s_stay(2'h3) |-> !ck_buf_en && !cmd_buf_en) else $error("self refresh buffers");
   a_active_en: assert property (s_stay(2'h0) ##0 $past(cke, 3) |-> int_clk_en && out_drv_en && cmd_buf_en)
      else $error("not enabled");
   a_drv_off: assert property (!cke |-> ##3 !out_drv_en) else $error("drivers on with clock enable low");
   a_io_drv: assert property (io_edge |-> out_drv_en || $past(out_drv_en)) else $error("edge with drivers off");
endmodule

//--- verif/dca_ctl_model.sv
// controller model driving the command, address and clock-enable pins
`timescale 1ns/1ps
module dca_ctl_model (
   input  wire logic   clk,             // system clock
   output logic        clk_true,        // link clock
   output logic        clk_complement,  // link clock inverse
   output logic        cke,             // clock enable
   output logic        cs_n,            // chip select
   output logic        ras_n,           // row strobe
   output logic        cas_n,           // column strobe
   output logic        we_n,            // write enable
   output logic [13:0] addr,            // address
   output logic        bank_select_lsb, // bank bit 0
   output logic        bank_select_msb  // bank bit 1
);
   logic run;
   // ==========================================
   // link clock, parked low while stopped
   initial begin
      run = 1'b1;
      clk_true = 1'b0;
      #3.1;
      forever #62.5 clk_true = run ? ~clk_true : 1'b0;
   end
   assign clk_complement = ~clk_true;
   // pins idle at power-up, clock enable low
   initial begin
      cke = 1'b0;
      cs_n = 1'b1;
      {ras_n, cas_n, we_n} = 3'h7;
      {bank_select_msb, bank_select_lsb} = 2'h0;
      addr = 14'h0000;
   end
   // one command per crossing, held past it, then lines scrambled
   task automatic issue(input logic k, s, input logic [2:0] c, input logic [1:0] b, input logic [13:0] a);
      @(negedge clk_true);
      @(posedge clk);
      cke <= k;
      cs_n <= s;
      {ras_n, cas_n, we_n} <= c;
      {bank_select_msb, bank_select_lsb} <= b;
      addr <= a;
      @(posedge clk_true);
      repeat (3) @(posedge clk);
      cs_n <= 1'b1;
      {ras_n, cas_n, we_n} <= 3'h7;
      addr <= ~a;
      repeat (4) @(posedge clk);
   endtask
   task automatic halt();
      @(negedge clk_true);
      run = 1'b0;
   endtask
   task automatic wake();
      @(posedge clk);
      cke <= 1'b1;
   endtask
   task automatic go();
      run = 1'b1;
   endtask
endmodule

//--- verif/ddr_sdram_cmd_addr_clock_enable_tb.sv
// self-checking bench for the command front end
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end
module ddr_sdram_cmd_addr_clock_enable_tb;
   logic        clk, reset, clk_true, clk_complement, cke, cs_n, ras_n, cas_n, we_n, bank_select_lsb, bank_select_msb;
   logic        act_strobe, rd_strobe, wr_strobe, pre_strobe, ref_strobe, mode_strobe, ext_mode_strobe, clr;
   logic        auto_pre, pre_all, int_clk_en, out_drv_en, cmd_buf_en, ck_buf_en, io_edge, chk_open;
   logic [13:0] addr, row_addr, mode_opcode, op;
   logic [11:0] col_addr;
   logic [3:0]  bank_open, open;
   logic [1:0]  cmd_bank, pwr_state, pst;
   logic [6:0]  seen;
   logic [15:0] rnd;
   int          err_total, checks, n, io_n;
   // ==========================================
   // clock, strobe capture, parts
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always_ff @(posedge clk) seen <= clr ? 7'h00 : seen | {act_strobe, rd_strobe, wr_strobe, pre_strobe, ref_strobe,
      mode_strobe, ext_mode_strobe};
   // count output timing pulses
   always_ff @(posedge clk) io_n <= reset ? 0 : io_n + int'(io_edge);
   dca_ctl_model u_ctl (.clk, .clk_true, .clk_complement, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr,
      .bank_select_lsb, .bank_select_msb);
   dca_cmd_front u_dut (.clk, .reset, .clk_true, .clk_complement, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr,
      .bank_select_lsb, .bank_select_msb, .act_strobe, .rd_strobe, .wr_strobe, .pre_strobe, .ref_strobe,
      .mode_strobe, .ext_mode_strobe, .cmd_bank, .row_addr, .col_addr, .auto_pre, .pre_all, .mode_opcode,
      .bank_open, .pwr_state, .int_clk_en, .out_drv_en, .cmd_buf_en, .ck_buf_en, .io_edge);
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // model one command, send it, compare
   task automatic cmd(input logic k, s, input logic [2:0] c, input logic [1:0] b, input logic [13:0] a);
      logic [6:0] e;
      e = 7'h00;
      if (!k) begin
         if (pst == 2'h0) pst = (c == dca_pkg::CMD_REF && !s && open == 4'h0) ? 2'h3 : (open != 4'h0 ? 2'h2 : 2'h1);
      end else if (pst != 2'h0) pst = 2'h0;
      else if (!s) begin
         case (c)
            dca_pkg::CMD_ACT: e = 7'h40;
            dca_pkg::CMD_RD:  e = 7'h20;
            dca_pkg::CMD_WR:  e = 7'h10;
            dca_pkg::CMD_PRE: e = 7'h08;
            dca_pkg::CMD_REF: e = 7'h04;
            dca_pkg::CMD_MRS: e = (b == 2'h0) ? 7'h02 : (b == 2'h1) ? 7'h01 : 7'h00;
            default:          e = 7'h00;
         endcase
      end
      if (e[6]) open[b] = 1'b1;
      if (e[3] & a[10]) open = 4'h0;
      else if (e[3] | ((e[5] | e[4]) & a[10])) open[b] = 1'b0;
      if (e[1:0] != 2'h0) op = a;
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      u_ctl.issue(k, s, c, b, a);
      `CHK(seen, e)
      if (e[6]) `CHK(row_addr, a)
      if (e[5] | e[4]) `CHK({auto_pre, col_addr}, {a[10], a[12:11], a[9:0]})
      if (e[6:3] != 4'h0) `CHK(cmd_bank, b)
      if (e[3]) `CHK(pre_all, a[10])
      `CHK(mode_opcode, op)
      `CHK(pwr_state, pst)
      if (chk_open) `CHK(bank_open, open)
   endtask
   task automatic rcmd(input logic [2:0] c, input logic [1:0] b);
      rnd = lfsr(rnd);
      cmd(1'b1, 1'b0, c, b, rnd[13:0]);
   endtask
   task automatic test_done();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // watchdog
   initial begin
      #100000;
      err_total++;
      test_done();
   end
   // main sequence
   initial begin
      {reset, clr, chk_open, pst, open, op, rnd, err_total, checks} = {3'h7, 2'h1, 4'h0, 14'h0000, 16'h0002, 64'h0};
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      `CHK({pwr_state, ck_buf_en, cmd_buf_en, int_clk_en}, 5'h0c)
      cmd(1'b1, 1'b0, dca_pkg::CMD_NOP, 2'h0, 14'h0000);
      `CHK({int_clk_en, out_drv_en, cmd_buf_en}, 3'h7)
      for (int i = 0; i < 4; i++) rcmd(dca_pkg::CMD_ACT, i[1:0]);
      cmd(1'b1, 1'b0, dca_pkg::CMD_PRE, 2'h2, 14'h0000);
      for (int i = 0; i < 4; i++) rcmd(dca_pkg::CMD_MRS, i[1:0]);
      cmd(1'b1, 1'b1, dca_pkg::CMD_ACT, 2'h2, 14'h0155);
      `CHK(io_n > 0, 1'b1)
      $display("test decode done");
      cmd(1'b0, 1'b0, dca_pkg::CMD_NOP, 2'h0, 14'h0000);
      cmd(1'b0, 1'b0, dca_pkg::CMD_ACT, 2'h2, 14'h0aaa);
      cmd(1'b1, 1'b0, dca_pkg::CMD_NOP, 2'h0, 14'h0000);
      cmd(1'b1, 1'b0, dca_pkg::CMD_PRE, 2'h0, 14'h0400);
      cmd(1'b0, 1'b0, dca_pkg::CMD_NOP, 2'h0, 14'h0000);
      cmd(1'b1, 1'b0, dca_pkg::CMD_NOP, 2'h0, 14'h0000);
      cmd(1'b0, 1'b0, dca_pkg::CMD_REF, 2'h0, 14'h0000);
      u_ctl.halt();
      `CHK({int_clk_en, out_drv_en, cmd_buf_en, ck_buf_en}, 4'h0)
      u_ctl.wake();
      for (n = 0; n < 10 && pwr_state !== 2'h0; n++) @(posedge clk);
      `CHK(pwr_state, 2'h0)
      pst = 2'h0;
      u_ctl.go();
      cmd(1'b1, 1'b0, dca_pkg::CMD_NOP, 2'h0, 14'h0000);
      $display("test power done");
      for (int i = 0; i < 4; i++) begin
         rcmd(dca_pkg::CMD_ACT, i[1:0]);
         rcmd(i[0] ? dca_pkg::CMD_RD : dca_pkg::CMD_WR, i[1:0]);
      end
      rcmd(dca_pkg::CMD_REF, 2'h0);
      $display("test access done");
      test_done();
   end
endmodule
bind dca_cmd_front dca_cmd_front_props u_props (.clk, .reset, .cke, .act_strobe, .rd_strobe, .wr_strobe,
   .pre_strobe, .ref_strobe, .mode_strobe, .ext_mode_strobe, .cmd_bank, .pre_all, .bank_open, .pwr_state,
   .int_clk_en, .out_drv_en, .cmd_buf_en, .ck_buf_en, .io_edge);
